// ### dcx_defs.svh
`ifndef DCX_DEFS_SVH
`define DCX_DEFS_SVH

// Register indices; byte address is four times the index
`define DCX_IDX_CCX       8'h0a
`define DCX_IDX_FX        8'h0b
`define DCX_IDX_CTRL      8'h10
`define DCX_IDX_CADDR     8'h11
`define DCX_IDX_STAT      8'h12

// Qualifier extension fields
`define DCX_CCX_DIR_EN    7
`define DCX_CCX_DIR_VAL   6
`define DCX_CCX_PAGE      5
`define DCX_CCX_B16       0

// Extended information fields
`define DCX_FX_PAGED_ACCESS_FLAG      7
`define DCX_FX_B16        0

// Own control fields
`define DCX_CTRL_ENABLE   0
`define DCX_CTRL_BEGIN    1
`define DCX_CTRL_LOOP     2

// Reset values
`define DCX_RST_CTRL_BEGIN 1'b1
`define DCX_RST_CADDR      16'h0000

// Bus answers
`define DCX_RESP_OKAY     2'b00
`define DCX_RESP_SLVERR   2'b10

`endif

// ### dcx_pkg.sv
package dcx_pkg;

  typedef enum logic [1:0] {
    DCX_ST_IDLE = 2'b01,
    DCX_ST_BUSY = 2'b10
  } dcx_state_e;

  // Core bus view, one cycle per valid
  typedef struct packed {
    logic        valid;
    logic        rnw;
    logic        page_sel;
    logic        linear_sel;
    logic [2:0]  prog_page;
    logic [15:0] cpu_addr;
    logic [16:0] lin_addr;
  } dcx_core_bus_s;

  typedef struct packed {
    logic dir_en;
    logic dir_val;
    logic page_q;
    logic b16;
  } dcx_ccx_s;

  typedef struct packed {
    logic paged_access_flag;
    logic b16;
  } dcx_fx_s;

  typedef struct packed {
    logic enable;
    logic begin_t;
    logic loop;
  } dcx_ctrl_s;

  typedef struct packed {
    dcx_state_e  wst;
    dcx_state_e  rst;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  waddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    dcx_ccx_s    ccx;
    logic [15:0] comp_addr;
    dcx_fx_s     fx;
    dcx_ctrl_s   ctrl;
    logic        match;
    logic        fifo_store;
  } dcx_state_s;

endpackage

// ### dcx_comp_c_ext.sv
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "dcx_defs.svh"

// Behaviour
// - With direction matching disabled, comparator C ignores whether a cycle reads or writes.
// - With direction matching enabled, a value of 0 matches writes only and 1 matches reads only.
// - Comparator C matches only when the page-select signal equals the page qualify bit.
// - A paged access is compared as the 3-bit program page above CPU address bits 13 to 0.
// - An unpaged access is compared as the CPU address with bit 16 zero, or a linear pointer.
// - Core address bit 16 is compared against the stored extension bit.
// - Each stored change-of-flow word carries the page-select flag, readable in bit 7 of the info register.
// - A flag of 0 marks event data or an unpaged address, including a linear pointer; 1 marks a paged flash address.
// - Bit 0 of the info register returns bit 16 of the address in the current trace word.
// - An end-trace reset with the module enabled and trigger at end keeps the extension bits.
// - In loop mode a stored change-of-flow address and its flag also go into comparator C.
// - The begin/end bit selects whether a trigger starts or stops storing; 0 means at the end.
// - The module enable is forced to zero and cannot be set while the part is secure.
module dcx_comp_c_ext #(
  parameter int CORE_AW = 17
) (
  // Clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   end_run_reset,
  // AXI4-Lite write
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output var  logic                   s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output var  logic                   s_axi_wready,
  output var  logic [1:0]             s_axi_bresp,
  output var  logic                   s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output var  logic                   s_axi_arready,
  output var  logic [31:0]            s_axi_rdata,
  output var  logic [1:0]             s_axi_rresp,
  output var  logic                   s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // Core side
  input  wire dcx_pkg::dcx_core_bus_s core,
  input  wire logic                   secure,
  input  wire logic                   cof_strobe,
  input  wire logic                   event_strobe,
  // Trace side
  output var  logic                   comp_c_match,
  output var  logic                   fifo_store,
  output var  logic                   trigger_at_end_n,
  output var  logic                   loop_capture_mode,
  output var  logic                   debug_module_enable
);
  import dcx_pkg::*;

  if (CORE_AW != 17) begin : g_chk
    $error("dcx_comp_c_ext: core address must be 17 bits");
  end

  dcx_state_s s;
  dcx_state_s next_s;

  function automatic logic [16:0] form_addr(input dcx_core_bus_s b);
    if (b.page_sel) begin
      form_addr = {b.prog_page, b.cpu_addr[13:0]};
    end else if (b.linear_sel) begin
      form_addr = b.lin_addr;
    end else begin
      form_addr = {1'b0, b.cpu_addr};
    end
  endfunction

  // Address, bit 16 and page agree; direction is handled by the caller
  function automatic logic addr_hit(input dcx_ccx_s c, input logic [15:0] ca,
                                    input logic [16:0] a, input logic psel);
    addr_hit = (a[15:0] == ca) && (a[16] == c.b16) && (psel == c.page_q);
  endfunction

  function automatic logic [7:0] idx_of(input logic [7:0] a);
    idx_of = {2'b00, a[7:2]};
  endfunction

  logic [16:0] cur_addr;
  logic        dir_ok;
  logic        loop_hit;
  logic        preserve;
  logic        do_store;
  logic [7:0]  ridx;
  logic [7:0]  widx;

  always_comb begin
    cur_addr = form_addr(core);
    dir_ok   = !s.ccx.dir_en || (core.rnw == s.ccx.dir_val);
    loop_hit = addr_hit(s.ccx, s.comp_addr, cur_addr, core.page_sel);
    preserve = end_run_reset && s.ctrl.enable && !s.ctrl.begin_t;
    ridx     = idx_of(s_axi_araddr);
    widx     = idx_of(s.waddr);
    do_store = 1'b0;
    next_s   = s;

    // Comparator C, one registered match per bus cycle
    next_s.match = core.valid && s.ctrl.enable && dir_ok &&
                   addr_hit(s.ccx, s.comp_addr, cur_addr, core.page_sel);

    // Trace word capture
    next_s.fifo_store = 1'b0;
    if (s.ctrl.enable && cof_strobe) begin
      // A loop repeat is dropped so tight loops do not flood the buffer
      do_store = !(s.ctrl.loop && loop_hit);
      if (do_store) begin
        next_s.fifo_store = 1'b1;
        next_s.fx.paged_access_flag   = core.page_sel;
        next_s.fx.b16     = cur_addr[16];
        if (s.ctrl.loop) begin
          next_s.comp_addr  = cur_addr[15:0];
          next_s.ccx.b16    = cur_addr[16];
          next_s.ccx.page_q = core.page_sel;
        end
      end
    end else if (s.ctrl.enable && event_strobe) begin
      next_s.fifo_store = 1'b1;
      next_s.fx         = '0;
    end

    // Write channel
    if (s.awready && s_axi_awvalid) begin
      next_s.aw_got  = 1'b1;
      next_s.awready = 1'b0;
      next_s.waddr   = s_axi_awaddr;
    end
    if (s.wready && s_axi_wvalid) begin
      next_s.w_got  = 1'b1;
      next_s.wready = 1'b0;
      next_s.wdata  = s_axi_wdata;
      next_s.wstrb  = s_axi_wstrb;
    end
    case (s.wst)
      DCX_ST_IDLE: begin
        if (s.aw_got && s.w_got) begin
          next_s.wst    = DCX_ST_BUSY;
          next_s.bvalid = 1'b1;
          next_s.bresp  = `DCX_RESP_OKAY;
          if (widx == `DCX_IDX_CCX) begin
            if (s.wstrb[0]) begin
              next_s.ccx.dir_en  = s.wdata[`DCX_CCX_DIR_EN];
              next_s.ccx.dir_val = s.wdata[`DCX_CCX_DIR_VAL];
              next_s.ccx.page_q  = s.wdata[`DCX_CCX_PAGE];
              next_s.ccx.b16     = s.wdata[`DCX_CCX_B16];
            end
          end else if (widx == `DCX_IDX_FX) begin
            next_s.bresp = `DCX_RESP_OKAY;
          end else if (widx == `DCX_IDX_CTRL) begin
            if (s.wstrb[0]) begin
              next_s.ctrl.enable  = s.wdata[`DCX_CTRL_ENABLE];
              next_s.ctrl.begin_t = s.wdata[`DCX_CTRL_BEGIN];
              next_s.ctrl.loop    = s.wdata[`DCX_CTRL_LOOP];
            end
          end else if (widx == `DCX_IDX_CADDR) begin
            if (s.wstrb[0]) begin
              next_s.comp_addr[7:0] = s.wdata[7:0];
            end
            if (s.wstrb[1]) begin
              next_s.comp_addr[15:8] = s.wdata[15:8];
            end
          end else if (widx != `DCX_IDX_STAT) begin
            next_s.bresp = `DCX_RESP_SLVERR;
          end
        end
      end
      DCX_ST_BUSY: begin
        if (s_axi_bready) begin
          next_s.wst     = DCX_ST_IDLE;
          next_s.bvalid  = 1'b0;
          next_s.aw_got  = 1'b0;
          next_s.w_got   = 1'b0;
          next_s.awready = 1'b1;
          next_s.wready  = 1'b1;
        end
      end
      default: begin
        next_s.wst = DCX_ST_IDLE;
      end
    endcase

    // Read channel
    case (s.rst)
      DCX_ST_IDLE: begin
        if (s_axi_arvalid) begin
          next_s.rst     = DCX_ST_BUSY;
          next_s.arready = 1'b0;
          next_s.rvalid  = 1'b1;
          next_s.rresp   = `DCX_RESP_OKAY;
          next_s.rdata   = 32'h0000_0000;
          if (ridx == `DCX_IDX_CCX) begin
            next_s.rdata[`DCX_CCX_DIR_EN]  = s.ccx.dir_en;
            next_s.rdata[`DCX_CCX_DIR_VAL] = s.ccx.dir_val;
            next_s.rdata[`DCX_CCX_PAGE]    = s.ccx.page_q;
            next_s.rdata[`DCX_CCX_B16]     = s.ccx.b16;
          end else if (ridx == `DCX_IDX_FX) begin
            next_s.rdata[`DCX_FX_PAGED_ACCESS_FLAG] = s.fx.paged_access_flag;
            next_s.rdata[`DCX_FX_B16]   = s.fx.b16;
          end else if (ridx == `DCX_IDX_CTRL) begin
            next_s.rdata[`DCX_CTRL_ENABLE] = s.ctrl.enable;
            next_s.rdata[`DCX_CTRL_BEGIN]  = s.ctrl.begin_t;
            next_s.rdata[`DCX_CTRL_LOOP]   = s.ctrl.loop;
          end else if (ridx == `DCX_IDX_CADDR) begin
            next_s.rdata[15:0] = s.comp_addr;
          end else if (ridx == `DCX_IDX_STAT) begin
            next_s.rdata[0] = s.match;
          end else begin
            next_s.rresp = `DCX_RESP_SLVERR;
          end
        end
      end
      DCX_ST_BUSY: begin
        if (s_axi_rready) begin
          next_s.rst     = DCX_ST_IDLE;
          next_s.rvalid  = 1'b0;
          next_s.arready = 1'b1;
        end
      end
      default: begin
        next_s.rst = DCX_ST_IDLE;
      end
    endcase

    if (!aresetn) begin
      next_s            = '0;
      next_s.wst        = DCX_ST_IDLE;
      next_s.rst        = DCX_ST_IDLE;
      next_s.awready    = 1'b1;
      next_s.wready     = 1'b1;
      next_s.arready    = 1'b1;
      next_s.comp_addr  = `DCX_RST_CADDR;
      next_s.ctrl.begin_t = `DCX_RST_CTRL_BEGIN;
      if (preserve) begin
        next_s.ccx       = s.ccx;
        next_s.fx        = s.fx;
        next_s.comp_addr = s.comp_addr;
        next_s.ctrl      = s.ctrl;
      end
    end

    // Last, so neither software nor a kept end-run state can enable a secure part
    if (secure) begin
      next_s.ctrl.enable = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    s <= next_s;
  end

  assign s_axi_awready       = s.awready;
  assign s_axi_wready        = s.wready;
  assign s_axi_bvalid        = s.bvalid;
  assign s_axi_bresp         = s.bresp;
  assign s_axi_arready       = s.arready;
  assign s_axi_rvalid        = s.rvalid;
  assign s_axi_rresp         = s.rresp;
  assign s_axi_rdata         = s.rdata;
  assign comp_c_match        = s.match;
  assign fifo_store          = s.fifo_store;
  assign trigger_at_end_n    = s.ctrl.begin_t;
  assign loop_capture_mode   = s.ctrl.loop;
  assign debug_module_enable = s.ctrl.enable;

  // Helpers read only by the checks below
  logic page_top;
  assign page_top = core.prog_page[2];

  sequence s_loop_miss;
    cof_strobe && s.ctrl.enable && s.ctrl.loop && !core.page_sel && !core.linear_sel &&
    ((core.cpu_addr != s.comp_addr) || s.ccx.b16 || s.ccx.page_q);
  endsequence

  sequence s_loop_repeat;
    cof_strobe && s.ctrl.enable && s.ctrl.loop && loop_hit;
  endsequence

  property p_dir_free;
    @(posedge aclk) disable iff (!aresetn)
    (core.valid && s.ctrl.enable && !s.ccx.dir_en && !core.page_sel && !core.linear_sel &&
     !s.ccx.page_q && !s.ccx.b16 && core.cpu_addr == s.comp_addr) |=> s.match;
  endproperty
  a_dir_free: assert property (p_dir_free) else $error("unqualified hit missed");

  property p_dir_block;
    @(posedge aclk) disable iff (!aresetn)
    (core.valid && s.ccx.dir_en && core.rnw != s.ccx.dir_val) |=> !s.match;
  endproperty
  a_dir_block: assert property (p_dir_block) else $error("wrong direction matched");

  property p_page_block;
    @(posedge aclk) disable iff (!aresetn)
    (core.valid && core.page_sel != s.ccx.page_q) |=> !s.match;
  endproperty
  a_page_block: assert property (p_page_block) else $error("page qualifier ignored");

  property p_paged_hit;
    @(posedge aclk) disable iff (!aresetn)
    (core.valid && s.ctrl.enable && !s.ccx.dir_en && core.page_sel && s.ccx.page_q &&
     {core.prog_page, core.cpu_addr[13:0]} == {s.ccx.b16, s.comp_addr}) |=> s.match;
  endproperty
  a_paged_hit: assert property (p_paged_hit) else $error("paged address not formed");

  property p_b16_block;
    @(posedge aclk) disable iff (!aresetn)
    (core.valid && !core.page_sel && !core.linear_sel && s.ccx.b16) |=> !s.match;
  endproperty
  a_b16_block: assert property (p_b16_block) else $error("bit 16 not forced low");

  property p_paged_word;
    @(posedge aclk) disable iff (!aresetn)
    (cof_strobe && s.ctrl.enable && !s.ctrl.loop && core.page_sel) |=>
      (s.fifo_store && s.fx.paged_access_flag && s.fx.b16 == $past(page_top));
  endproperty
  a_paged_word: assert property (p_paged_word) else $error("paged flag or bit 16 lost");

  property p_event_word;
    @(posedge aclk) disable iff (!aresetn)
    (event_strobe && !cof_strobe && s.ctrl.enable) |=> (s.fifo_store && s.fx == '0);
  endproperty
  a_event_word: assert property (p_event_word) else $error("event word flagged");

  property p_loop_miss;
    @(posedge aclk) disable iff (!aresetn)
    s_loop_miss |=> (s.fifo_store && s.comp_addr == $past(core.cpu_addr) && !s.ccx.page_q);
  endproperty
  a_loop_miss: assert property (p_loop_miss) else $error("loop address not copied");

  property p_loop_repeat;
    @(posedge aclk) disable iff (!aresetn)
    s_loop_repeat |=> !s.fifo_store;
  endproperty
  a_loop_repeat: assert property (p_loop_repeat) else $error("loop repeat stored");

  property p_secure;
    @(posedge aclk) disable iff (!aresetn)
    secure |=> !s.ctrl.enable [*2] or !secure;
  endproperty
  a_secure: assert property (p_secure) else $error("enable set while secure");

  property p_cold_reset;
    @(posedge aclk)
    (!aresetn && !end_run_reset) |=> (s.fx == '0 && s.ccx == '0);
  endproperty
  a_cold_reset: assert property (p_cold_reset) else $error("extension bits survived");

  property p_fx_read;
    @(posedge aclk) disable iff (!aresetn)
    (s.arready && s_axi_arvalid && idx_of(s_axi_araddr) == `DCX_IDX_FX) |=>
      (s.rvalid && s.rdata[6:1] == 6'h00 && s.rdata[7] == $past(s.fx.paged_access_flag));
  endproperty
  a_fx_read: assert property (p_fx_read) else $error("info read wrong");

endmodule
`default_nettype wire

// ### dcx_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module dcx_core_model (
  // Clock
  input  wire logic           aclk,
  // Core bus view
  output var  dcx_pkg::dcx_core_bus_s core,
  output var  logic           cof_strobe,
  output var  logic           event_strobe
);
  import dcx_pkg::*;
  initial begin
    core = '0;
    cof_strobe = 1'b0;
    event_strobe = 1'b0;
  end
  // One bus cycle; afterwards the lines flip so a stale value never looks valid
  task automatic send(input dcx_core_bus_s c, input logic change_of_flow, input logic evt);
    dcx_core_bus_s idle;
    idle = ~c;
    idle.valid = 1'b0;
    c.valid = 1'b1;
    @(posedge aclk);
    core <= c;
    cof_strobe <= change_of_flow;
    event_strobe <= evt;
    @(posedge aclk);
    core <= idle;
    cof_strobe <= 1'b0;
    event_strobe <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### dcx_comp_c_ext_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "dcx_defs.svh"
module dcx_comp_c_ext_tb_top;
  import dcx_pkg::*;
  typedef struct packed {
    logic [7:0]    ccx;
    dcx_core_bus_s c;
    logic          exp;
  } dcx_row_s;
  localparam logic [7:0] addr_ccx = `DCX_IDX_CCX << 2;
  localparam logic [7:0] addr_fx = `DCX_IDX_FX << 2;
  localparam logic [7:0] addr_ctrl = `DCX_IDX_CTRL << 2;
  localparam logic [7:0] addr_caddr = `DCX_IDX_CADDR << 2;
  logic          aclk = 1'b0;
  logic          aresetn = 1'b0;
  logic          end_run_reset = 1'b0;
  logic          secure = 1'b0;
  logic [7:0]    awaddr = 8'h00;
  logic          awvalid = 1'b0;
  logic [31:0]   wdata = 32'h0000_0000;
  logic          wvalid = 1'b0;
  logic          bready = 1'b0;
  logic [7:0]    araddr = 8'h00;
  logic          arvalid = 1'b0;
  logic          rready = 1'b0;
  logic          awready, wready, bvalid, arready, rvalid;
  logic [1:0]    bresp, rresp;
  logic [31:0]   rdata, rd;
  logic [1:0]    rs;
  wire dcx_core_bus_s core_bus;
  wire logic     change_of_flow, evt;
  logic          match, store, tae_n, loop_mode, dbg_en;
  int            bad_count = 0;
  int            samples_checked = 0;
  dcx_row_s      rows [14];

  always #2.5 aclk = ~aclk;

  dcx_comp_c_ext #(.CORE_AW(17)) u_dcx_comp_c_ext (
    .aclk(aclk), .aresetn(aresetn), .end_run_reset(end_run_reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .core(core_bus), .secure(secure), .cof_strobe(change_of_flow), .event_strobe(evt),
    .comp_c_match(match), .fifo_store(store), .trigger_at_end_n(tae_n),
    .loop_capture_mode(loop_mode), .debug_module_enable(dbg_en));

  dcx_core_model u_dcx_core_model (
    .aclk(aclk), .core(core_bus), .cof_strobe(change_of_flow), .event_strobe(evt));

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_flag(input string n, input logic e, input logic g);
    chk_reg(n, {31'h0, e}, {31'h0, g});
  endtask

  task automatic hang();
    bad_count++;
    $display("ERROR bus wait ran out");
    test_done();
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 50) hang();
    bready <= 1'b0;
    chk_reg("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 50) hang();
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    axi_rd(a, rd, rs);
    chk_reg(n, e, rd);
  endtask

  // Reset held two edges; end-run marks it as an end-trace reset
  task automatic do_reset(input logic endrun);
    @(posedge aclk);
    end_run_reset <= endrun;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    end_run_reset <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic cap(input dcx_core_bus_s c, input logic cf, input logic ev,
                     input logic es, input logic [31:0] efx);
    u_dcx_core_model.send(c, cf, ev);
    @(posedge aclk);
    chk_flag("fifo_store", es, store);
    rd_chk("info", addr_fx, efx);
  endtask

  function automatic dcx_core_bus_s mk(input logic r, input logic p, input logic l,
                                       input logic [2:0] pp, input logic [15:0] a,
                                       input logic [16:0] la);
    mk = '{1'b1, r, p, l, pp, a, la};
  endfunction

  initial begin
    rows[0] = '{8'h00, mk(1, 0, 0, 3'h0, 16'h1234, 17'h0_0000), 1'b1};
    rows[1] = '{8'h00, mk(0, 0, 0, 3'h0, 16'h1234, 17'h0_0000), 1'b1};
    rows[2] = '{8'h80, mk(0, 0, 0, 3'h0, 16'h1234, 17'h0_0000), 1'b1};
    rows[3] = '{8'h80, mk(1, 0, 0, 3'h0, 16'h1234, 17'h0_0000), 1'b0};
    rows[4] = '{8'hc0, mk(1, 0, 0, 3'h0, 16'h1234, 17'h0_0000), 1'b1};
    rows[5] = '{8'hc0, mk(0, 0, 0, 3'h0, 16'h1234, 17'h0_0000), 1'b0};
    rows[6] = '{8'h40, mk(0, 0, 0, 3'h0, 16'h1234, 17'h0_0000), 1'b1};
    rows[7] = '{8'h00, mk(1, 1, 0, 3'h0, 16'h1234, 17'h0_0000), 1'b0};
    rows[8] = '{8'h20, mk(1, 0, 0, 3'h0, 16'h1234, 17'h0_0000), 1'b0};
    rows[9] = '{8'h21, mk(1, 1, 0, 3'h4, 16'hd234, 17'h0_0000), 1'b1};
    rows[10] = '{8'h20, mk(1, 1, 0, 3'h4, 16'hd234, 17'h0_0000), 1'b0};
    rows[11] = '{8'h01, mk(1, 0, 1, 3'h0, 16'h0000, 17'h1_1234), 1'b1};
    rows[12] = '{8'h00, mk(1, 0, 1, 3'h0, 16'h0000, 17'h1_1234), 1'b0};
    rows[13] = '{8'h00, mk(1, 0, 0, 3'h0, 16'h1235, 17'h0_0000), 1'b0};
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk("qualifier", addr_ccx, 32'h0000_0000);
    rd_chk("info", addr_fx, 32'h0000_0000);
    chk_flag("trigger_at_end_n", 1'b1, tae_n);
    axi_wr(addr_ctrl, 32'h0000_0001, `DCX_RESP_OKAY);
    chk_flag("trigger_at_end_n", 1'b0, tae_n);
    chk_flag("enable", 1'b1, dbg_en);
    axi_wr(addr_caddr, 32'h0000_1234, `DCX_RESP_OKAY);
    foreach (rows[i]) begin
      axi_wr(addr_ccx, {24'h0, rows[i].ccx}, `DCX_RESP_OKAY);
      u_dcx_core_model.send(rows[i].c, 1'b0, 1'b0);
      @(posedge aclk);
      chk_flag("comp_c_match", rows[i].exp, match);
    end
    axi_wr(addr_ccx, 32'h0000_0000, `DCX_RESP_OKAY);
    cap(mk(1, 1, 0, 3'h5, 16'h0055, 17'h0_0000), 1, 0, 1, 32'h0000_0081);
    cap(mk(1, 0, 1, 3'h0, 16'h0000, 17'h1_0000), 1, 0, 1, 32'h0000_0001);
    cap(mk(1, 1, 0, 3'h7, 16'hffff, 17'h0_0000), 0, 1, 1, 32'h0000_0000);
    axi_wr(addr_fx, 32'h0000_00ff, `DCX_RESP_OKAY);
    rd_chk("info", addr_fx, 32'h0000_0000);
    axi_wr(8'h3c, 32'h0000_0001, `DCX_RESP_SLVERR);
    axi_rd(8'h3c, rd, rs);
    chk_reg("rresp", {30'h0, `DCX_RESP_SLVERR}, {30'h0, rs});
    // Loop mode: a new change of flow is stored and reloads comparator C
    axi_wr(addr_ctrl, 32'h0000_0005, `DCX_RESP_OKAY);
    chk_flag("loop", 1'b1, loop_mode);
    cap(mk(0, 1, 0, 3'h6, 16'h0abc, 17'h0_0000), 1, 0, 1, 32'h0000_0081);
    rd_chk("comp_addr", addr_caddr, 32'h0000_8abc);
    rd_chk("qualifier", addr_ccx, 32'h0000_0021);
    cap(mk(1, 1, 0, 3'h6, 16'h0abc, 17'h0_0000), 1, 0, 0, 32'h0000_0081);
    do_reset(1'b1);
    rd_chk("info", addr_fx, 32'h0000_0081);
    rd_chk("qualifier", addr_ccx, 32'h0000_0021);
    chk_flag("trigger_at_end_n", 1'b0, tae_n);
    cap(mk(0, 0, 0, 3'h0, 16'h0abc, 17'h0_0000), 1, 0, 1, 32'h0000_0000);
    rd_chk("comp_addr", addr_caddr, 32'h0000_0abc);
    cap(mk(0, 1, 0, 3'h6, 16'h0abc, 17'h0_0000), 1, 0, 1, 32'h0000_0081);
    do_reset(1'b0);
    rd_chk("info", addr_fx, 32'h0000_0000);
    rd_chk("qualifier", addr_ccx, 32'h0000_0000);
    chk_flag("trigger_at_end_n", 1'b1, tae_n);
    @(posedge aclk);
    secure <= 1'b1;
    axi_wr(addr_ctrl, 32'h0000_0001, `DCX_RESP_OKAY);
    rd_chk("control", addr_ctrl, 32'h0000_0000);
    chk_flag("enable", 1'b0, dbg_en);
    test_done();
  end
endmodule
`default_nettype wire
